//--- hw/rtc_alarm_defines.svh
// constants for the two-wire target with the daily-alarm registers
// assumes inclusion by bare name from the design file
`ifndef RTC_ALARM_DEFINES_SVH
`define RTC_ALARM_DEFINES_SVH

`define TARGET_ADDR 7'h32
`define ALARM_MIN_ADDR 4'hB
`define ALARM_HOUR_ADDR 4'hC
`define PTR_AFTER_STOP 4'hF
`define FMT_READ_NOW_A 4'h4
`define FMT_READ_NOW_B 4'h5
`define ALARM_MIN_RESET 8'h00
`define ALARM_HOUR_RESET 8'h00
`define ALARM_MIN_MASK 8'h7F
`define ALARM_HOUR_MASK 8'h3F
`define UNMAPPED_READ 8'h00
`define BITS_PER_BYTE 4'h8
`define CNT_MAX 4'h9

`endif

//--- hw/rtc_alarm_pkg.sv
// types for the two-wire target with the daily-alarm registers
// assumes nothing beyond the constants header
`default_nettype none

package rtc_alarm_pkg;

    // gray codes along address, ack, data and ack again
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_DATA  = 3'h2,
        ST_WR_ACK   = 3'h6,
        ST_RD_DATA  = 3'h7,
        ST_RD_ACK   = 3'h5,
        ST_IGNORE   = 3'h4
    } link_state_t;

endpackage

`default_nettype wire

//--- hw/rtc_alarm_target.sv
// two-wire serial target of the clock, holding the daily-alarm minute and hour
// assumes scl_clk and scl_in carry the same wire; sda and scl are open drain
//
// What this block does
// R1 - Alarm minute at internal address B, BCD in bits 6..0, bit 7 reads zero.
// R2 - Alarm hour at internal address C, bits 5..0, bits 7..6 read zero.
// R3 - Hour bit 5 is PM flag in 12-hour mode, tens bit in 24-hour.
// R4 - In 12-hour mode midnight is stored as 12, noon as 32.
// R5 - Host must never load a nonexistent alarm time.
// R6 - Clock and data lines only pulled low or released, never driven high.
// R7 - Data changes only while clock is low.
// R8 - Data falling while clock high is a start; access begins.
// R9 - Data rising while clock high is a stop; access ends.
// R10 - Only the master makes start and stop conditions.
// R11 - After start, data moves in 8-bit bytes, any number of them.
// R12 - Transmitter releases data after eighth fall; receiver pulls low for ack.
// R13 - Receiver releases ack at ninth fall, or starts sending if it transmits.
// R14 - Master withholds ack after the last byte it wants to read.
// R15 - After an unacked byte the device keeps data released for the stop.
// R16 - First byte holds 7-bit address MSB first, then direction bit.
// R17 - Direction bit high means read, low means write.
// R18 - The device answers to address 0110010.
// R19 - Stop ends a transfer; start before stop is a repeated start.
// R20 - Master uses repeated start to reverse direction in one access.
// R21 - Foreign address gets no ack and the rest of the transfer is ignored.
// R22 - First written byte holds pointer in upper nibble, format in lower.
// R23 - Pointer advances after each further data byte, wrapping F to 0.
// R24 - Every stop loads F into the pointer.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_defines.svh"

module rtc_alarm_target (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic [7:0] alarm_minute,
    output logic [7:0] alarm_hour,
    output logic [3:0] reg_ptr
);
    import rtc_alarm_pkg::*;

    // link domain: byte shifter on rising scl
    logic [7:0] rx_sh_r;

    // stable for half a bit time before the local domain reads it
    always_ff @(posedge scl_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sh_r <= 8'h00;
        end else begin
            rx_sh_r <= {rx_sh_r[6:0], sda_in}; // see R16
        end
    end

    // pin synchronisers
    logic scl_m_r, scl_s_r, scl_q_r;
    logic sda_m_r, sda_s_r, sda_q_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
        end
    end

    logic scl_rise, scl_fall, start_evt, stop_evt;
    assign scl_rise = scl_s_r && !scl_q_r;
    assign scl_fall = !scl_s_r && scl_q_r;
    assign start_evt = scl_s_r && scl_q_r && !sda_s_r && sda_q_r; // see R8
    assign stop_evt = scl_s_r && scl_q_r && sda_s_r && !sda_q_r;  // see R9

    link_state_t state_r;
    logic [3:0] cnt_r;
    logic [3:0] ptr_r;
    logic [3:0] fmt_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic first_r;
    logic sda_oe_r;
    logic [7:0] min_r;
    logic [7:0] hour_r;

    function automatic logic [7:0] rd_byte(input logic [3:0] p, input logic [7:0] m,
                                           input logic [7:0] h);
        logic [7:0] v;
        v = `UNMAPPED_READ;
        if (p == `ALARM_MIN_ADDR) begin
            v = m;
        end else if (p == `ALARM_HOUR_ADDR) begin
            v = h;
        end
        return v;
    endfunction

    logic [7:0] rd_now;
    logic byte_done, addr_match, wr_commit, fmt_read_now;
    assign rd_now = rd_byte(ptr_r, min_r, hour_r);
    assign byte_done = scl_fall && (cnt_r == `BITS_PER_BYTE); // see R11
    assign addr_match = (rx_sh_r[7:1] == `TARGET_ADDR);       // see R18
    assign wr_commit = (state_r == ST_WR_DATA) && byte_done && !first_r;
    assign fmt_read_now = (fmt_r == `FMT_READ_NOW_A) || (fmt_r == `FMT_READ_NOW_B);

    // transfer sequencing, pointer and data line
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            ptr_r <= `PTR_AFTER_STOP;
            fmt_r <= 4'h0;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_evt) begin
            state_r <= ST_IDLE;                                // see R9
            ptr_r <= `PTR_AFTER_STOP;                          // see R24
            sda_oe_r <= 1'b0;
        end else if (start_evt) begin
            state_r <= ST_ADDR;                                // see R8, R19
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else begin
            if (scl_rise && cnt_r != `CNT_MAX) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (scl_fall) begin
                unique case (state_r)
                    ST_IDLE, ST_IGNORE: begin
                    end
                    ST_ADDR: begin
                        if (byte_done) begin
                            if (addr_match) begin
                                state_r <= ST_ADDR_ACK;
                                sda_oe_r <= 1'b1;              // see R12
                                rw_r <= rx_sh_r[0];            // see R17
                            end else begin
                                state_r <= ST_IGNORE;          // see R21
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            state_r <= ST_RD_DATA;             // see R13
                            tx_r <= rd_now;
                            sda_oe_r <= !rd_now[7];            // see R6
                        end else begin
                            state_r <= ST_WR_DATA;
                            sda_oe_r <= 1'b0;                  // see R13
                            first_r <= 1'b1;
                        end
                    end
                    ST_WR_DATA: begin
                        if (byte_done) begin
                            state_r <= ST_WR_ACK;
                            sda_oe_r <= 1'b1;                  // see R12
                            if (first_r) begin
                                ptr_r <= rx_sh_r[7:4];         // see R22
                                fmt_r <= rx_sh_r[3:0];
                            end else begin
                                ptr_r <= ptr_r + 4'h1;         // see R23
                            end
                        end
                    end
                    ST_WR_ACK: begin
                        cnt_r <= 4'h0;
                        first_r <= 1'b0;
                        if (first_r && fmt_read_now) begin
                            state_r <= ST_RD_DATA;
                            tx_r <= rd_now;
                            sda_oe_r <= !rd_now[7];
                        end else begin
                            state_r <= ST_WR_DATA;
                            sda_oe_r <= 1'b0;                  // see R13
                        end
                    end
                    ST_RD_DATA: begin
                        if (byte_done) begin
                            state_r <= ST_RD_ACK;
                            sda_oe_r <= 1'b0;                  // see R12
                            ptr_r <= ptr_r + 4'h1;             // see R23
                        end else begin
                            sda_oe_r <= !tx_r[6];              // see R7
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                    end
                    ST_RD_ACK: begin
                        cnt_r <= 4'h0;
                        if (!rx_sh_r[0]) begin
                            state_r <= ST_RD_DATA;
                            tx_r <= rd_now;
                            sda_oe_r <= !rd_now[7];
                        end else begin
                            state_r <= ST_IGNORE;              // see R15
                            sda_oe_r <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // alarm registers; unused bits forced to zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            min_r <= `ALARM_MIN_RESET;
            hour_r <= `ALARM_HOUR_RESET;
        end else if (wr_commit) begin
            if (ptr_r == `ALARM_MIN_ADDR) begin
                min_r <= rx_sh_r & `ALARM_MIN_MASK;           // see R1
            end
            if (ptr_r == `ALARM_HOUR_ADDR) begin
                hour_r <= rx_sh_r & `ALARM_HOUR_MASK;         // see R2, R3, R4
            end
        end
    end

    // output flops; lines are only ever pulled low
    logic sda_out_r, scl_out_r, scl_oe_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out_r <= 1'b0;
            scl_out_r <= 1'b0;
            scl_oe_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;                                 // see R6
            scl_out_r <= 1'b0;
            scl_oe_r <= 1'b0;
        end
    end

    assign sda_out = sda_out_r;
    assign sda_oe = sda_oe_r;
    assign scl_out = scl_out_r;
    assign scl_oe = scl_oe_r;
    assign alarm_minute = min_r;
    assign alarm_hour = hour_r;
    assign reg_ptr = ptr_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_lines_never_high: assert property (!scl_oe && !sda_out && !scl_out) // see R6
        else $error("a line is driven high or scl is held");
    a_start_begins: assert property (start_evt && !stop_evt |=> state_r == ST_ADDR) // see R8
        else $error("start did not begin an access");
    a_stop_loads_ptr: assert property (stop_evt |=> ptr_r == 4'hF && state_r == ST_IDLE) // see R24
        else $error("stop did not reset pointer");
    a_addr_ack: assert property (!stop_evt && !start_evt && state_r == ST_ADDR && byte_done
        && addr_match |=> sda_oe_r && state_r == ST_ADDR_ACK) // see R18
        else $error("own address not acknowledged");
    a_foreign_nack: assert property (!stop_evt && !start_evt && state_r == ST_ADDR
        && byte_done && !addr_match |=> !sda_oe_r && state_r == ST_IGNORE) // see R21
        else $error("foreign address acknowledged");
    a_ack_release: assert property (!stop_evt && !start_evt && state_r == ST_ADDR_ACK
        && scl_fall && !rw_r |=> !sda_oe_r) // see R13
        else $error("ack not released at ninth fall");
    a_nack_hold: assert property (!stop_evt && !start_evt && state_r == ST_RD_ACK && scl_fall
        && rx_sh_r[0] |=> !sda_oe_r [*2]) // see R15
        else $error("data not released after nack");
    a_ptr_wrap: assert property (!stop_evt && !start_evt && wr_commit && ptr_r == 4'hF
        |=> ptr_r == 4'h0) // see R23
        else $error("pointer did not wrap");
    a_reg_zero_bits: assert property (alarm_minute[7] == 1'b0
        && alarm_hour[7:6] == 2'b00) // see R1
        else $error("reserved alarm bits not zero");
    a_oe_scl_low: assert property ($changed(sda_oe_r) |-> !scl_s_r) // see R7
        else $error("data line changed while clock high");
    a_min_write: assert property (wr_commit && ptr_r == `ALARM_MIN_ADDR
        |=> min_r == ($past(rx_sh_r) & `ALARM_MIN_MASK)) // see R1
        else $error("minute write did not land");
    a_read_first_bit: assert property (!stop_evt && !start_evt && state_r == ST_ADDR_ACK
        && scl_fall && rw_r |=> sda_oe_r == !$past(rd_now[7])) // see R13
        else $error("first read bit not driven after address ack");

    c_write_byte: cover property (wr_commit);
    c_read_acked: cover property (state_r == ST_RD_ACK && scl_fall && !rx_sh_r[0]);
    c_repeated_start: cover property (start_evt && state_r == ST_WR_DATA);
    c_format_read: cover property (state_r == ST_WR_ACK && scl_fall && first_r && fmt_read_now);
    c_read_nack: cover property (state_r == ST_RD_ACK ##1 state_r == ST_IGNORE);

endmodule

`default_nettype wire

//--- tb/i2c_master_model.sv
// bus master model that drives clock and data of the two-wire link
// assumes the bench resolves both wires with pull-ups and feeds sda back
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    output logic scl_m,
    output logic sda_m,
    input wire logic sda
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end

    // low phase stretched so the target's answer settles before the rise
    task automatic put_bit(input logic b, output logic seen);
        #36 sda_m = b;
        #9 scl_m = 1'b1;
        #7 seen = sda;
        #8 scl_m = 1'b0;
    endtask

    // also serves as a repeated start
    task automatic start_cond();
        #36 sda_m = 1'b1;
        scl_m = 1'b1;
        #40 sda_m = 1'b0;
        #40 scl_m = 1'b0;
    endtask

    task automatic stop_cond();
        #36 sda_m = 1'b0;
        #10 scl_m = 1'b1;
        #40 sda_m = 1'b1;
        #40;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, ack_n);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(nack, s);
    endtask
endmodule

`default_nettype wire

//--- tb/rtc_alarm_target_test.sv
// self-checking bench for the two-wire target with the alarm registers
// assumes the master model above; alarm values are legal times except the A5 and E3 writes with unused upper bits set
`timescale 1ns/1ps
`default_nettype none

module rtc_alarm_target_test;
    import rtc_alarm_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic scl_m, sda_m, sda_out, sda_oe, scl_out, scl_oe;
    logic [7:0] alarm_minute, alarm_hour;
    logic [3:0] reg_ptr;
    wire scl, sda;
    int error_cnt = 0;
    int checked = 0;

    assign sda = sda_m & ~sda_oe;
    assign scl = scl_m & ~scl_oe;

    always #4 clk = ~clk;

    rtc_alarm_target i_rtc_alarm_target (
        .clk(clk), .reset_n(reset_n), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
        .alarm_minute(alarm_minute), .alarm_hour(alarm_hour), .reg_ptr(reg_ptr)
    );

    i2c_master_model i_i2c_master_model (.scl_m(scl_m), .sda_m(sda_m), .sda(sda));

    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic st();
        i_i2c_master_model.start_cond();
    endtask

    task automatic sp();
        i_i2c_master_model.stop_cond();
    endtask

    task automatic wr(input logic [7:0] b, input logic exp_ack_n);
        logic a;
        i_i2c_master_model.send_byte(b, a);
        chk("ack", {7'h00, a}, {7'h00, exp_ack_n});
    endtask

    task automatic rd(input logic nack, input logic [7:0] exp);
        logic [7:0] d;
        i_i2c_master_model.recv_byte(nack, d);
        chk("read data", d, exp);
    endtask

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        repeat (4) @(negedge clk);
        #3.3;
        chk("minute reset", alarm_minute, 8'h00);
        chk("hour reset", alarm_hour, 8'h00);
        chk("pointer reset", {4'h0, reg_ptr}, 8'h0F);
        // minute then hour in one transfer, midnight of 12-hour mode
        st();
        wr(8'h64, 1'b0);
        wr(8'hB0, 1'b0);
        wr(8'h59, 1'b0);
        wr(8'h12, 1'b0);
        chk("pointer advance", {4'h0, reg_ptr}, 8'h0D);
        sp();
        chk("minute", alarm_minute, 8'h59);
        chk("hour", alarm_hour, 8'h12);
        chk("pointer stop", {4'h0, reg_ptr}, 8'h0F);
        // unused upper bits
        st();
        wr(8'h64, 1'b0);
        wr(8'hB0, 1'b0);
        wr(8'hA5, 1'b0);
        wr(8'hE3, 1'b0);
        sp();
        chk("minute top bit", alarm_minute, 8'h25);
        chk("hour top bits", alarm_hour, 8'h23);
        // noon, then both back through a repeated start
        st();
        wr(8'h64, 1'b0);
        wr(8'hC0, 1'b0);
        wr(8'h32, 1'b0);
        sp();
        st();
        wr(8'h64, 1'b0);
        wr(8'hB0, 1'b0);
        st();
        wr(8'h65, 1'b0);
        rd(1'b0, 8'h25);
        rd(1'b1, 8'h32);
        #40;
        chk("release after nack", {7'h00, sda_oe}, 8'h00);
        sp();
        // foreign address is left alone
        st();
        wr(8'h66, 1'b1);
        wr(8'hB0, 1'b1);
        wr(8'h00, 1'b1);
        sp();
        chk("minute kept", alarm_minute, 8'h25);
        // format code 4 turns to reading at once
        st();
        wr(8'h64, 1'b0);
        wr(8'hC4, 1'b0);
        rd(1'b1, 8'h32);
        sp();
        // read straight after the address starts at F
        st();
        wr(8'h65, 1'b0);
        rd(1'b1, 8'h00);
        sp();
        // pointer wraps from F to 0
        st();
        wr(8'h64, 1'b0);
        wr(8'hF0, 1'b0);
        wr(8'h00, 1'b0);
        wr(8'h00, 1'b0);
        chk("pointer wrap", {4'h0, reg_ptr}, 8'h01);
        sp();
        chk("hour kept", alarm_hour, 8'h32);
        chk("pin drive", {5'h00, sda_out, scl_out, scl_oe}, 8'h00);
        give_verdict();
    end
endmodule

`default_nettype wire
